// ### logic/i2c_arbitration_wakeup_reservation.sv
`default_nettype none

module toggle_sync (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic tgl_in,
   output logic pulse_out
);
   logic meta_r;
   logic sync_r;
   logic prev_r;
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         meta_r <= 1'h0;
         sync_r <= 1'h0;
         prev_r <= 1'h0;
      end else begin
         meta_r <= tgl_in;
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end
   assign pulse_out = sync_r ^ prev_r;
endmodule : toggle_sync

module level_sync #(
   parameter int W = 1
) (
   input wire logic clk_in,
   input wire logic [W-1:0] lvl_in,
   output logic [W-1:0] lvl_out
);
   logic [W-1:0] meta_r;
   always_ff @(posedge clk_in) begin
      meta_r <= lvl_in;
      lvl_out <= meta_r;
   end
endmodule : level_sync

module i2c_arbitration_wakeup_reservation #(
   parameter int WIDTH_W = i2c_mm_pkg::WIDTH_DEFAULT
) (
   input wire logic mclk_in,
   input wire logic rst_in,
   input wire logic link_clk_in,
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe_out,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out,
   input wire logic start_request_bit_in,
   input wire logic leave_bus_bit_in,
   input wire logic shift_wr_in,
   input wire logic [7:0] shift_data_in,
   input wire logic clear_lost_in,
   input wire logic clear_start_in,
   input wire logic wait_timing_select_in,
   input wire logic stop_interrupt_enable_in,
   input wire logic wake_on_address_in,
   input wire logic reservation_disable_in,
   input wire logic [i2c_mm_pkg::ADDR_BITS-1:0] own_address_in,
   input wire logic [WIDTH_W-1:0] low_width_setting_in,
   input wire logic [WIDTH_W-1:0] high_width_setting_in,
   output logic bus_event_interrupt_out,
   output logic arbitration_lost_flag_out,
   output logic start_detected_flag_out,
   output logic master_state_flag_out,
   output logic bus_busy_out,
   output logic reservation_pending_out,
   output logic wake_request_out
);
   import i2c_mm_pkg::*;

   localparam int CFG_W = ADDR_BITS + 2 * WIDTH_W;
   localparam logic [CFG_W-1:0] CFG_RST = {OWN_ADDR_RST,
      WIDTH_W'(LOW_WIDTH_RST), WIDTH_W'(HIGH_WIDTH_RST)};

   // ************************************************************
   // Software side requests
   // ************************************************************
   logic st_tgl_r, leave_tgl_r, wr_tgl_r, cfg_req_r, cfg_ack_m;
   logic [7:0] tx_hold_r;
   logic [CFG_W-1:0] cfg_now, cfg_hold_r;
   logic master_m, busy_m, rsv_m, int_p, lost_p, std_p;
   logic int_out_r, lost_flag_r, std_flag_r;

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         st_tgl_r <= 1'h0;
         leave_tgl_r <= 1'h0;
         wr_tgl_r <= 1'h0;
         tx_hold_r <= 8'h00;
      end else begin
         if (start_request_bit_in) begin
            st_tgl_r <= ~st_tgl_r;
         end
         if (leave_bus_bit_in) begin
            leave_tgl_r <= ~leave_tgl_r;
         end
         // Held until the next write; link side copies it after sync
         if (shift_wr_in) begin
            tx_hold_r <= shift_data_in;
            wr_tgl_r <= ~wr_tgl_r;
         end
      end
   end

   // Width and address words cross by a request/acknowledge handshake
   assign cfg_now = {own_address_in, low_width_setting_in,
      high_width_setting_in};
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         cfg_hold_r <= CFG_RST;
         cfg_req_r <= 1'h0;
      end else if (cfg_req_r == cfg_ack_m && cfg_now != cfg_hold_r) begin
         cfg_hold_r <= cfg_now;
         cfg_req_r <= ~cfg_req_r;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         lost_flag_r <= 1'h0;
      end else if (lost_p) begin
         lost_flag_r <= 1'h1;
      end else if (clear_lost_in) begin
         lost_flag_r <= 1'h0;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         std_flag_r <= 1'h0;
      end else if (std_p) begin
         std_flag_r <= 1'h1;
      end else if (clear_start_in) begin
         std_flag_r <= 1'h0;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         int_out_r <= 1'h0;
      end else begin
         int_out_r <= int_p;
      end
   end

   assign bus_event_interrupt_out = int_out_r;
   assign arbitration_lost_flag_out = lost_flag_r;
   assign start_detected_flag_out = std_flag_r;
   assign master_state_flag_out = master_m;
   assign bus_busy_out = busy_m;
   assign reservation_pending_out = rsv_m;

   // ************************************************************
   // Domain crossings
   // ************************************************************
   logic lrst_meta_r, lrst_r, st_req_p, leave_p, wr_p;
   logic cfg_req_l, cfg_ack_r, wtim_l, spie_l, rsv_dis_l, wup_l;
   logic scl_s, sda_s, int_tgl_r, lost_tgl_r, std_tgl_r;
   logic rsv_pend_r, rsv_armed_r, busy_r;
   role_t role_r;

   always_ff @(posedge link_clk_in) begin
      lrst_meta_r <= rst_in;
      lrst_r <= lrst_meta_r;
   end

   toggle_sync u_st (.clk_in(link_clk_in), .rst_in(lrst_r),
      .tgl_in(st_tgl_r), .pulse_out(st_req_p));
   toggle_sync u_leave (.clk_in(link_clk_in), .rst_in(lrst_r),
      .tgl_in(leave_tgl_r), .pulse_out(leave_p));
   toggle_sync u_wr (.clk_in(link_clk_in), .rst_in(lrst_r),
      .tgl_in(wr_tgl_r), .pulse_out(wr_p));
   toggle_sync u_int (.clk_in(mclk_in), .rst_in(rst_in),
      .tgl_in(int_tgl_r), .pulse_out(int_p));
   toggle_sync u_lost (.clk_in(mclk_in), .rst_in(rst_in),
      .tgl_in(lost_tgl_r), .pulse_out(lost_p));
   toggle_sync u_std (.clk_in(mclk_in), .rst_in(rst_in),
      .tgl_in(std_tgl_r), .pulse_out(std_p));
   level_sync #(.W(5)) u_cfg_l (.clk_in(link_clk_in),
      .lvl_in({cfg_req_r, wait_timing_select_in,
         stop_interrupt_enable_in, reservation_disable_in,
         wake_on_address_in}),
      .lvl_out({cfg_req_l, wtim_l, spie_l, rsv_dis_l, wup_l}));
   level_sync #(.W(2)) u_pins (.clk_in(link_clk_in),
      .lvl_in({scl_in, sda_in}), .lvl_out({scl_s, sda_s}));
   level_sync #(.W(4)) u_stat (.clk_in(mclk_in),
      .lvl_in({cfg_ack_r, role_r == R_MASTER, busy_r, rsv_pend_r}),
      .lvl_out({cfg_ack_m, master_m, busy_m, rsv_m}));

   // ************************************************************
   // Link side: configuration, bus edges, bit count
   // ************************************************************
   logic [ADDR_BITS-1:0] own_addr_r;
   logic [WIDTH_W-1:0] lw_r;
   logic [WIDTH_W-1:0] hw_r;
   logic scl_d_r, sda_d_r, addr_phase_r;
   logic [3:0] bitcnt_r;
   logic [7:0] rx_r;

   always_ff @(posedge link_clk_in) begin
      if (lrst_r) begin
         {own_addr_r, lw_r, hw_r} <= CFG_RST;
         cfg_ack_r <= 1'h0;
      end else if (cfg_req_l != cfg_ack_r) begin
         {own_addr_r, lw_r, hw_r} <= cfg_hold_r;
         cfg_ack_r <= cfg_req_l;
      end
   end

   always_ff @(posedge link_clk_in) begin
      if (lrst_r) begin
         scl_d_r <= 1'h1;
         sda_d_r <= 1'h1;
      end else begin
         scl_d_r <= scl_s;
         sda_d_r <= sda_s;
      end
   end

   wire scl_rise = scl_s & ~scl_d_r;
   wire scl_fall = ~scl_s & scl_d_r;
   wire start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
   wire stop_det = scl_s & scl_d_r & ~sda_d_r & sda_s;
   wire fall8 = scl_fall && bitcnt_r == BIT_CNT_BYTE;
   wire fall9 = scl_fall && bitcnt_r == BIT_CNT_ACK;
   wire addr_match = rx_r[7:1] == own_addr_r;
   wire ext_code = rx_r[7:4] == EXT_NIB_LOW || rx_r[7:4] == EXT_NIB_HIGH;
   wire addr_hit = addr_phase_r && (addr_match || ext_code);

   always_ff @(posedge link_clk_in) begin
      if (lrst_r) begin
         bitcnt_r <= BIT_CNT_ZERO;
         rx_r <= 8'h00;
         addr_phase_r <= 1'h0;
      end else if (start_det) begin
         bitcnt_r <= BIT_CNT_ZERO;
         addr_phase_r <= 1'h1;
      end else if (stop_det || fall9) begin
         bitcnt_r <= BIT_CNT_ZERO;
         addr_phase_r <= 1'h0;
      end else if (scl_rise && bitcnt_r != BIT_CNT_ACK) begin
         bitcnt_r <= bitcnt_r + 4'h1;
         if (bitcnt_r != BIT_CNT_BYTE) begin
            rx_r <= {rx_r[6:0], sda_s};
         end
      end
   end

   // ************************************************************
   // Link side: master drive and arbitration
   // ************************************************************
   drive_state_t drv_r;
   logic [WIDTH_W-1:0] cnt_r;
   logic [7:0] tx_sh_r;
   logic sda_drv_r, tx_ready_r, ack_drv_r, lost_pend_r;

   wire free_role = role_r == R_NONE || role_r == R_EXCLUDED;
   wire start_go = drv_r == L_IDLE &&
      ((st_req_p && free_role && !busy_r) || (rsv_armed_r && wr_p));
   wire lose_bit = role_r == R_MASTER && drv_r == L_HIGH && scl_rise &&
      bitcnt_r < BIT_CNT_BYTE && tx_sh_r[7] && !sda_s;
   wire lose_start = (drv_r == L_START && !scl_s) ||
      (start_go && (!scl_s || !sda_s));
   wire lost = lose_bit || lose_start;

   always_ff @(posedge link_clk_in) begin
      if (lrst_r) begin
         drv_r <= L_IDLE;
         cnt_r <= '0;
         tx_sh_r <= 8'h00;
         sda_drv_r <= 1'h0;
         tx_ready_r <= 1'h0;
      end else if (lost || leave_p ||
            (drv_r != L_IDLE && role_r != R_MASTER)) begin
         drv_r <= L_IDLE;
         cnt_r <= '0;
         sda_drv_r <= 1'h0;
      end else begin
         case (drv_r)
            L_IDLE: begin
               if (start_go) begin
                  drv_r <= L_START;
                  cnt_r <= '0;
                  sda_drv_r <= 1'h1;
                  tx_ready_r <= rsv_armed_r;
                  tx_sh_r <= tx_hold_r;
               end
            end
            L_START: begin
               if (cnt_r >= hw_r) begin
                  drv_r <= tx_ready_r ? L_LOW : L_WAIT;
                  cnt_r <= '0;
               end else begin
                  cnt_r <= cnt_r + 1'h1;
               end
            end
            // Clock held low until software supplies the byte
            L_WAIT: begin
               if (wr_p) begin
                  tx_sh_r <= tx_hold_r;
                  drv_r <= L_LOW;
                  cnt_r <= '0;
               end
            end
            L_LOW: begin
               if (fall9) begin
                  drv_r <= L_WAIT;
                  sda_drv_r <= 1'h0;
                  cnt_r <= '0;
               end else begin
                  if (scl_fall && bitcnt_r != BIT_CNT_ZERO) begin
                     tx_sh_r <= {tx_sh_r[6:0], 1'h1};
                  end
                  // Data moves only once the low clock is seen settled
                  if (!scl_s && !scl_d_r) begin
                     sda_drv_r <= bitcnt_r < BIT_CNT_BYTE && !tx_sh_r[7];
                     if (cnt_r >= lw_r) begin
                        drv_r <= L_HIGH;
                        cnt_r <= '0;
                     end else begin
                        cnt_r <= cnt_r + 1'h1;
                     end
                  end
               end
            end
            // follow a faster master's low edge
            L_HIGH: begin
               if (scl_s) begin
                  if (cnt_r >= hw_r) begin
                     drv_r <= L_LOW;
                     cnt_r <= '0;
                  end else begin
                     cnt_r <= cnt_r + 1'h1;
                  end
               end else if (cnt_r != '0) begin
                  drv_r <= L_LOW;
                  cnt_r <= '0;
               end
            end
            default: begin
               drv_r <= L_IDLE;
            end
         endcase
      end
   end

   // ************************************************************
   // Link side: role, interrupts, wake, reservation
   // ************************************************************
   logic wake_r;

   wire int_at8 = !wtim_l && (!addr_phase_r || ext_code);
   wire byte_end = int_at8 ? fall8 : fall9;
   wire eligible = lost_pend_r || role_r == R_MASTER ||
      role_r == R_SLAVE || (role_r == R_STANDBY && addr_hit);
   wire int_fire = (stop_det && spie_l) || (byte_end && eligible);

   always_ff @(posedge link_clk_in) begin
      if (lrst_r) begin
         busy_r <= 1'h0;
      end else if (start_det) begin
         busy_r <= 1'h1;
      end else if (stop_det) begin
         busy_r <= 1'h0;
      end
   end

   always_ff @(posedge link_clk_in) begin
      if (lrst_r) begin
         role_r <= R_NONE;
      end else if (lost) begin
         role_r <= R_STANDBY;
      end else if (stop_det) begin
         role_r <= R_NONE;
      end else if (leave_p && role_r != R_NONE) begin
         role_r <= R_EXCLUDED;
      end else if (start_go) begin
         role_r <= R_MASTER;
      end else if (start_det && role_r != R_MASTER) begin
         role_r <= R_STANDBY;
      end else if (fall8 && addr_phase_r && role_r == R_STANDBY) begin
         role_r <= addr_hit ? R_SLAVE : R_EXCLUDED;
      end else if (fall9 && role_r == R_STANDBY) begin
         role_r <= R_EXCLUDED;
      end
   end

   always_ff @(posedge link_clk_in) begin
      if (lrst_r) begin
         lost_pend_r <= 1'h0;
      end else if (lost) begin
         lost_pend_r <= 1'h1;
      end else if (int_fire || stop_det) begin
         lost_pend_r <= 1'h0;
      end
   end

   always_ff @(posedge link_clk_in) begin
      if (lrst_r) begin
         int_tgl_r <= 1'h0;
         lost_tgl_r <= 1'h0;
         std_tgl_r <= 1'h0;
      end else begin
         int_tgl_r <= int_tgl_r ^ int_fire;
         lost_tgl_r <= lost_tgl_r ^ lost;
         std_tgl_r <= std_tgl_r ^ start_det;
      end
   end

   // Ack own address or extension code unless leaving
   always_ff @(posedge link_clk_in) begin
      if (lrst_r) begin
         ack_drv_r <= 1'h0;
      end else if (leave_p || fall9 || stop_det) begin
         ack_drv_r <= 1'h0;
      end else if (fall8 && role_r == R_STANDBY && addr_hit) begin
         ack_drv_r <= 1'h1;
      end
   end

   always_ff @(posedge link_clk_in) begin
      if (lrst_r) begin
         wake_r <= 1'h0;
      end else if (!wup_l) begin
         wake_r <= 1'h0;
      end else if (byte_end && addr_hit &&
            (role_r == R_STANDBY || role_r == R_SLAVE)) begin
         wake_r <= 1'h1;
      end
   end

   always_ff @(posedge link_clk_in) begin
      if (lrst_r || rsv_dis_l) begin
         rsv_pend_r <= 1'h0;
         rsv_armed_r <= 1'h0;
      end else if (start_go) begin
         rsv_pend_r <= 1'h0;
         rsv_armed_r <= 1'h0;
      // arm on stop, writes before ignored
      end else if (stop_det && rsv_pend_r) begin
         rsv_pend_r <= 1'h0;
         rsv_armed_r <= 1'h1;
      end else if (start_det && rsv_armed_r) begin
         rsv_pend_r <= 1'h1;
         rsv_armed_r <= 1'h0;
      end else if (st_req_p && free_role && busy_r &&
            drv_r == L_IDLE) begin
         rsv_pend_r <= 1'h1;
      end
   end

   assign scl_out = 1'h0;
   assign sda_out = 1'h0;
   assign scl_oe_out = drv_r == L_WAIT || drv_r == L_LOW;
   assign sda_oe_out = sda_drv_r || ack_drv_r;
   assign wake_request_out = wake_r;
endmodule : i2c_arbitration_wakeup_reservation

`default_nettype wire

// ### shared/i2c_mm_pkg.sv
// What this block does
// - Keep clocking bits beside other masters until driven data differs.
// - On loss set the lost flag at once and release both lines.
// - Loss within a byte or ack interrupts at eighth or ninth fall.
// - Loss at a stop interrupts at the stop, only with stop enable.
// - Low lines during a start attempt interrupt at the byte end.
// - Ninth fall when wait select is one; when zero, eighth except ninth on an address that is no extension code.
// - As slave interrupt only on own address or extension code.
// - A start puts the block in wake standby through the address.
// - Stop interrupt depends only on the stop interrupt enable.
// - Wake mode receives addresses on the link clock alone.
// - Reservation is active while reservation disable is zero.
// - After loss the block is in standby for the address; after leaving the bus it is excluded.
// - Start request makes a start if bus free, else a reservation.
// - A reserved start uses the byte written after the stop.
`default_nettype none

package i2c_mm_pkg;
   localparam int WIDTH_DEFAULT = 8;
   localparam int ADDR_BITS = 7;
   localparam logic [3:0] BIT_CNT_ZERO = 4'h0;
   localparam logic [3:0] BIT_CNT_BYTE = 4'h8;
   localparam logic [3:0] BIT_CNT_ACK = 4'h9;
   localparam logic [3:0] EXT_NIB_LOW = 4'h0;
   localparam logic [3:0] EXT_NIB_HIGH = 4'hF;
   localparam logic [7:0] LOW_WIDTH_RST = 8'h10;
   localparam logic [7:0] HIGH_WIDTH_RST = 8'h10;
   localparam logic [6:0] OWN_ADDR_RST = 7'h00;

   typedef enum logic [2:0] {
      L_IDLE = 3'b000,
      L_START = 3'b001,
      L_WAIT = 3'b010,
      L_LOW = 3'b011,
      L_HIGH = 3'b100
   } drive_state_t;

   typedef enum logic [2:0] {
      R_NONE = 3'b000,
      R_MASTER = 3'b001,
      R_STANDBY = 3'b010,
      R_SLAVE = 3'b011,
      R_EXCLUDED = 3'b100
   } role_t;
endpackage : i2c_mm_pkg

`default_nettype wire

// ### tb/bus_partner.sv
`default_nettype none

module bus_partner (
   input wire logic link_clk_in,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic scl_pull_out,
   output logic sda_pull_out,
   output logic [8:0] rx_out
);
   timeunit 1ns;
   timeprecision 100ps;

   // ********
   // Other master on the bus
   // ********
   // Half bus clock, in link cycles
   localparam int PH = 4;

   initial {scl_pull_out, sda_pull_out} = 2'b00;

   always @(posedge scl_in) begin
      rx_out <= {rx_out[7:0], sda_in};
   end

   task automatic wait_l(input int n);
      repeat (n) @(posedge link_clk_in);
   endtask : wait_l

   task automatic start_c;
      wait_l(1);
      sda_pull_out <= 1'b1;
      wait_l(PH);
      scl_pull_out <= 1'b1;
   endtask : start_c

   // Ack is read off the real wire
   task automatic send_byte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= -1; i--) begin
         wait_l(1);
         sda_pull_out <= (i >= 0) && !b[i];
         wait_l(PH);
         scl_pull_out <= 1'b0;
         wait_l(PH);
         ack = sda_in;
         scl_pull_out <= 1'b1;
      end
   endtask : send_byte

   task automatic stop_c;
      wait_l(1);
      scl_pull_out <= 1'b1;
      wait_l(1);
      sda_pull_out <= 1'b1;
      wait_l(PH);
      scl_pull_out <= 1'b0;
      wait_l(PH);
      sda_pull_out <= 1'b0;
      wait_l(PH);
   endtask : stop_c

   // clock pulled low while the other start is held
   task automatic clash;
      wait (sda_in === 1'b0);
      wait_l(1);
      scl_pull_out <= 1'b1;
   endtask : clash
endmodule : bus_partner

`default_nettype wire

// ### tb/i2c_arbitration_wakeup_reservation_test.sv
`default_nettype none

module i2c_arbitration_wakeup_reservation_test;
   timeunit 1ns;
   timeprecision 100ps;
   import i2c_mm_pkg::*;

   // ********
   // Stimulus and wiring
   // ********
   localparam logic [4:0] DO_START = 5'h10;
   localparam logic [4:0] DO_WR = 5'h08;
   localparam logic [4:0] DO_LEAVE = 5'h04;
   localparam logic [4:0] DO_CLRL = 5'h02;
   localparam logic [4:0] DO_CLRS = 5'h01;
   logic mclk_in = 1'b0;
   logic link_clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic [4:0] pls = 5'h00;
   logic [7:0] width = 8'h04;
   logic wait_timing_select_in = 1'b1;
   logic stop_interrupt_enable_in = 1'b1;
   logic wake_on_address_in = 1'b0;
   logic reservation_disable_in = 1'b0;
   logic [7:0] shift_data_in = 8'h00;
   logic [6:0] own_address_in = 7'h20;
   logic scl_out, scl_oe_out, sda_out, sda_oe_out, ack, p_scl, p_sda;
   logic bus_event_interrupt_out, arbitration_lost_flag_out;
   logic start_detected_flag_out, master_state_flag_out, bus_busy_out;
   logic reservation_pending_out, wake_request_out;
   logic [8:0] rx;
   logic [7:0] wdata;
   logic exp_q[$];
   int num_errors = 0;
   int checks_done = 0;
   int cycles = 0;
   // Open-drain lines with pull-ups
   wire logic scl_w = !(scl_oe_out || p_scl);
   wire logic sda_w = !(sda_oe_out || p_sda);

   i2c_arbitration_wakeup_reservation i_i2c_arbitration_wakeup_reservation (
      .start_request_bit_in(pls[4]), .shift_wr_in(pls[3]),
      .leave_bus_bit_in(pls[2]), .clear_lost_in(pls[1]),
      .clear_start_in(pls[0]), .scl_in(scl_w), .sda_in(sda_w),
      .low_width_setting_in(width), .high_width_setting_in(width), .*
   );

   bus_partner i_bus_partner (
      .link_clk_in, .scl_in(scl_w), .sda_in(sda_w),
      .scl_pull_out(p_scl), .sda_pull_out(p_sda), .rx_out(rx)
   );

   always #12.5 mclk_in = !mclk_in;
   initial begin
      #3.1;
      forever #62.5 link_clk_in = !link_clk_in;
   end

   task automatic err(input string m);
      num_errors++;
      $display("ERROR %0t %s", $time, m);
   endtask : err

   task automatic chk(input logic [7:0] g, input logic [7:0] e,
                      input string m);
      checks_done++;
      if (g !== e) begin
         err(m);
      end
   endtask : chk

   task automatic finish_test;
      $display("errors %0d checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : finish_test

   // Spaced apart: one shared holding register
   task automatic sw(input logic [4:0] p);
      repeat (20) @(posedge mclk_in);
      pls <= p;
      @(posedge mclk_in);
      pls <= 5'h00;
      repeat (100) @(posedge mclk_in);
   endtask : sw

   task automatic drain;
      for (int i = 0; i < 2000 && exp_q.size() != 0; i++) begin
         @(posedge mclk_in);
      end
      repeat (20) @(posedge mclk_in);
      chk(exp_q.size() == 0, 1'b1, "missing interrupt");
   endtask : drain

   task automatic end_frame(input logic lost_e);
      if (stop_interrupt_enable_in) begin
         exp_q.push_back(lost_e);
      end
      i_bus_partner.stop_c();
      drain();
      chk(bus_busy_out, 1'b0, "busy after stop");
   endtask : end_frame

   task automatic slave_xfer(input logic [7:0] b, input logic ack_e,
                             input logic int_e);
      i_bus_partner.start_c();
      if (int_e) begin
         exp_q.push_back(1'b0);
      end
      i_bus_partner.send_byte(b, ack);
      chk(ack, ack_e, "ack");
      chk(start_detected_flag_out, 1'b1, "start seen");
      end_frame(1'b0);
      sw(DO_CLRS);
   endtask : slave_xfer

   // lost flag read at each interrupt
   always @(posedge mclk_in) begin
      if (bus_event_interrupt_out === 1'b1) begin
         checks_done++;
         if (exp_q.size() == 0) begin
            err("unexpected interrupt");
         end else if (arbitration_lost_flag_out !== exp_q.pop_front()) begin
            err("lost flag at interrupt");
         end
      end
   end

   always @(posedge mclk_in) begin
      cycles++;
      if (cycles == 40000) begin
         err("timeout");
         finish_test();
      end
   end

   initial begin
      void'($urandom(32'h358B0379));
      own_address_in = 7'h20 + 7'($urandom % 64);
      wdata = 8'($urandom);
      width = 8'h04 + 8'($urandom % 4);
      repeat (10) @(posedge mclk_in);
      rst_in <= 1'b0;
      repeat (40) @(posedge mclk_in);
      chk(bus_busy_out, 1'b0, "idle busy");
      slave_xfer({own_address_in, 1'b0}, 1'b0, 1'b1);
      @(posedge mclk_in) stop_interrupt_enable_in <= 1'b0;
      slave_xfer({own_address_in ^ 7'h01, 1'b0}, 1'b1, 1'b0);
      @(posedge mclk_in) stop_interrupt_enable_in <= 1'b1;
      for (int k = 0; k < 2; k++) begin
         @(posedge mclk_in) wait_timing_select_in <= k[0];
         slave_xfer((k == 1) ? 8'hF1 : 8'h00, 1'b0, 1'b1);
      end
      @(posedge mclk_in) wake_on_address_in <= 1'b1;
      slave_xfer({own_address_in, 1'b0}, 1'b0, 1'b1);
      chk(wake_request_out, 1'b1, "wake set");
      @(posedge mclk_in) wake_on_address_in <= 1'b0;
      repeat (100) @(posedge mclk_in);
      chk(wake_request_out, 1'b0, "wake clear");
      shift_data_in <= wdata;
      sw(DO_START);
      chk(master_state_flag_out, 1'b1, "master");
      exp_q.push_back(1'b0);
      sw(DO_WR);
      drain();
      chk(rx[8:1], wdata, "sent byte");
      sw(DO_LEAVE);
      chk(master_state_flag_out, 1'b0, "left bus");
      end_frame(1'b0);
      exp_q.push_back(1'b1);
      fork
         i_bus_partner.clash();
         sw(DO_START);
      join
      i_bus_partner.send_byte({own_address_in ^ 7'h01, 1'b0}, ack);
      drain();
      chk(arbitration_lost_flag_out, 1'b1, "lost");
      chk(scl_oe_out || sda_oe_out || scl_out || sda_out, 1'b0,
          "released");
      chk(master_state_flag_out, 1'b0, "not master");
      end_frame(1'b1);
      sw(DO_CLRL);
      chk(arbitration_lost_flag_out, 1'b0, "lost clear");
      i_bus_partner.start_c();
      i_bus_partner.send_byte({own_address_in ^ 7'h01, 1'b0}, ack);
      @(posedge mclk_in) reservation_disable_in <= 1'b1;
      sw(DO_START);
      chk(reservation_pending_out, 1'b0, "refused");
      @(posedge mclk_in) reservation_disable_in <= 1'b0;
      sw(DO_START);
      chk(reservation_pending_out, 1'b1, "reserved");
      chk(master_state_flag_out, 1'b0, "reserved flag");
      shift_data_in <= ~wdata;
      sw(DO_WR);
      end_frame(1'b0);
      shift_data_in <= wdata;
      exp_q.push_back(1'b0);
      sw(DO_WR);
      drain();
      chk(master_state_flag_out, 1'b1, "reserved start");
      chk(rx[8:1], wdata, "reserved byte");
      sw(DO_LEAVE);
      end_frame(1'b0);
      finish_test();
   end
endmodule : i2c_arbitration_wakeup_reservation_test

`default_nettype wire

// ### tb/i2c_mm_sva.sv
`default_nettype none

module i2c_mm_sva (
   input wire logic mclk_in,
   input wire logic rst_in,
   input wire logic link_clk_in,
   input wire logic scl_oe_out,
   input wire logic sda_oe_out,
   input wire logic clear_lost_in,
   input wire logic wake_on_address_in,
   input wire logic reservation_disable_in,
   input wire logic bus_event_interrupt_out,
   input wire logic arbitration_lost_flag_out,
   input wire logic start_detected_flag_out,
   input wire logic master_state_flag_out,
   input wire logic bus_busy_out,
   input wire logic reservation_pending_out,
   input wire logic wake_request_out
);
   timeunit 1ns;
   timeprecision 100ps;

   // ********
   // Checks
   // ********
   property p_lost_rel;
      @(posedge mclk_in) disable iff (rst_in)
      $rose(arbitration_lost_flag_out) |-> !scl_oe_out && !sda_oe_out;
   endproperty
   a_lost_rel: assert property (p_lost_rel)
      else $error("lines still driven after loss");

   property p_lost_held;
      @(posedge mclk_in) disable iff (rst_in)
      arbitration_lost_flag_out && !clear_lost_in
      |=> arbitration_lost_flag_out;
   endproperty
   a_lost_held: assert property (p_lost_held)
      else $error("lost flag dropped");

   property p_int_pulse;
      @(posedge mclk_in) disable iff (rst_in)
      bus_event_interrupt_out |=> !bus_event_interrupt_out;
   endproperty
   a_int_pulse: assert property (p_int_pulse)
      else $error("long interrupt");

   property p_mst_drop;
      @(posedge mclk_in) disable iff (rst_in)
      $rose(arbitration_lost_flag_out) |-> ##[0:40] !master_state_flag_out;
   endproperty
   a_mst_drop: assert property (p_mst_drop)
      else $error("still master after loss");

   property p_busy_start;
      @(posedge mclk_in) disable iff (rst_in)
      $rose(start_detected_flag_out) |-> ##[0:8] bus_busy_out;
   endproperty
   a_busy_start: assert property (p_busy_start)
      else $error("start seen but bus not busy");

   property p_rsv_dis;
      @(posedge mclk_in) disable iff (rst_in)
      $rose(reservation_pending_out) |-> !reservation_disable_in;
   endproperty
   a_rsv_dis: assert property (p_rsv_dis)
      else $error("reservation while disabled");

   property p_rsv_nomst;
      @(posedge mclk_in) disable iff (rst_in)
      $rose(reservation_pending_out) |-> !master_state_flag_out [*8];
   endproperty
   a_rsv_nomst: assert property (p_rsv_nomst)
      else $error("master flag set with reservation");

   property p_wake_set;
      @(posedge link_clk_in) disable iff (rst_in)
      $rose(wake_request_out) |-> wake_on_address_in;
   endproperty
   a_wake_set: assert property (p_wake_set)
      else $error("stray wake");

   property p_wake_clr;
      @(posedge link_clk_in) disable iff (rst_in)
      !wake_on_address_in [*6] |-> !wake_request_out;
   endproperty
   a_wake_clr: assert property (p_wake_clr)
      else $error("wake kept");

   c_lost: cover property (@(posedge mclk_in)
      $rose(arbitration_lost_flag_out));
   c_rsv: cover property (@(posedge mclk_in)
      $rose(reservation_pending_out));
   c_wake: cover property (@(posedge link_clk_in)
      $rose(wake_request_out));
endmodule : i2c_mm_sva

bind i2c_arbitration_wakeup_reservation i2c_mm_sva i_i2c_mm_sva (.*);

`default_nettype wire
